// *** verilog/axis_regs_pkg.sv ***
// Purpose: shared constants and carriers for the axis position/status register group
// Assumes: 4-bit register select code, 24-bit data path
// Notes: select codes double as register addresses on the plain register port
package axis_regs_pkg;

    localparam int DATA_W = 24;
    localparam int SEL_W = 4;

    // read and write select codes
    localparam logic [3:0] SEL_ENV_WRITE = 4'h7;
    localparam logic [3:0] SEL_ENV_READ = 4'h6;
    localparam logic [3:0] SEL_PRODUCT_READ = 4'h7;
    localparam logic [3:0] SEL_POSITION = 4'h8;
    localparam logic [3:0] SEL_EXT_STATUS = 4'h9;
    localparam logic [3:0] SEL_PORT = 4'hA;
    localparam logic [3:0] SEL_IRQ_STATUS = 4'hD;
    localparam logic [3:0] SEL_IRQ_MASK = 4'hE;

    // environment register field positions
    localparam int ENV_W = 16;
    localparam int ENV_COMPAT = 1;
    localparam int ENV_ORIGIN_CLEAR = 7;
    localparam int ENV_COUNT_INHIBIT = 8;
    localparam int ENV_REVERSE = 9;
    localparam int ENV_TERM_SELECT = 11;
    localparam int ENV_PORT_DIR_LSB = 12;
    localparam logic [15:0] ENV_RESET = 16'h0000;

    // product information layout, placed on bits 23..16 of the read word
    localparam int PROD_LSB = 16;
    localparam int PROD_CODE_LSB = 4;
    localparam int PROD_VERSION = 3;
    localparam int PROD_MODE = 0;
    localparam int PROD_CODE_W = 4;
    localparam int EXT_W = 16;
    localparam logic [3:0] PRODUCT_CODE = 4'h5; // arbitrary value
    localparam logic PRODUCT_VERSION = 1'b0; // arbitrary value

    // port register layout
    localparam int PORTS = 4;
    localparam int PORT_UPDOWN = 4;
    localparam int PORT_FASTHOLD = 5;
    localparam logic [3:0] PORT_RESET = 4'h0;

    localparam logic [23:0] POSITION_RESET = 24'h000000;
    localparam logic [23:0] POSITION_ALL_ONES = 24'hFFFFFF;
    localparam logic [23:0] POSITION_ONE = 24'h000001;

    // interrupt status bits
    localparam int IRQ_W = 2;
    localparam int IRQ_ORIGIN_CLEAR = 0;
    localparam int IRQ_WRAP = 1;
    localparam logic [1:0] IRQ_RESET = 2'h0;

    typedef struct packed {
        logic [3:0] sel;
        logic [23:0] wdata;
        logic write;
        logic read;
    } reg_req_s;

    typedef struct packed {
        logic step;
        logic minus;
        logic active;
        logic originReturn;
    } pulse_s;

endpackage

// *** verilog/axis_position_status_regs.sv ***
// Purpose: per-axis position counter, extended status, product info and phase/port register
// Assumes: one clock, synchronous active-low reset, all inputs synchronous to clock
// Notes: register read data appears the cycle after the read strobe and only then
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ps

module axis_position_status_regs (
    input wire logic clock,
    input wire logic reset_n,
    input wire axis_regs_pkg::reg_req_s regRequest,
    output logic [23:0] regReadData,
    input wire axis_regs_pkg::pulse_s pulse,
    input wire logic originInput,
    input wire logic [15:0] extendedStatus,
    input wire logic [3:0] phaseOutputs,
    input wire logic [3:0] terminalIn,
    input wire logic updownTerminal,
    input wire logic fastholdTerminal,
    output logic [3:0] terminalOut,
    output logic [3:0] terminalOe,
    output logic [23:0] positionCount,
    output logic interrupt
);

    // shared select-code match for read and write decode
    function automatic logic selHit(input logic [3:0] sel, input logic [3:0] code);
        selHit = (sel == code);
    endfunction

    logic [23:0] position_reg;
    logic [23:0] position_next;
    logic [15:0] env_reg;
    logic [3:0] portLevel_reg;
    logic [1:0] irqStatus_reg;
    logic [1:0] irqMask_reg;
    logic [1:0] irqEvents;
    logic originPrev_reg;
    logic originHit;
    logic countEnable;
    logic countUp;
    logic wrapEvent;
    logic hostWrite;
    logic hostRead;
    logic [3:0] portDirIn;
    logic [23:0] readWord;
    logic originFell;
    logic [1:0] irqStatus_next;
    logic irqPending;

    // register decode strobes
    logic envWrite;
    logic positionWrite;
    logic portWrite;
    logic maskWrite;
    logic statusRead;

    // counter candidates and wrap flags
    logic [23:0] positionUp;
    logic [23:0] positionDown;
    logic upWrap;
    logic downWrap;

    // per-register read words
    logic [23:0] positionWord;
    logic [23:0] extStatusWord;
    logic [23:0] productWord;
    logic [23:0] envWord;
    logic [23:0] portWord;
    logic [23:0] irqStatusWord;
    logic [23:0] irqMaskWord;

    assign hostWrite = regRequest.write;
    assign hostRead = regRequest.read;
    assign portDirIn = env_reg[axis_regs_pkg::ENV_PORT_DIR_LSB +: axis_regs_pkg::PORTS];

    // one strobe per register so every consumer sees the same decode
    assign envWrite = hostWrite && selHit(regRequest.sel, axis_regs_pkg::SEL_ENV_WRITE);
    assign positionWrite = hostWrite && selHit(regRequest.sel, axis_regs_pkg::SEL_POSITION);
    assign portWrite = hostWrite && selHit(regRequest.sel, axis_regs_pkg::SEL_PORT);
    assign maskWrite = hostWrite && selHit(regRequest.sel, axis_regs_pkg::SEL_IRQ_MASK);
    assign statusRead = hostRead && selHit(regRequest.sel, axis_regs_pkg::SEL_IRQ_STATUS);

    // environment register: only the low 16 bits are kept, upper write bits are dropped
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            env_reg <= axis_regs_pkg::ENV_RESET;
        end else if (envWrite) begin
            env_reg <= regRequest.wdata[axis_regs_pkg::ENV_W-1:0];
        end
    end

    // origin level history for falling-edge detection
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            originPrev_reg <= 1'b1;
        end else begin
            originPrev_reg <= originInput;
        end
    end

    // falling edge of origin; history resets high, so an origin already low at reset release reads as an edge
    always_comb begin
        originFell = originPrev_reg && !originInput;
    end

    // idle: only a falling edge clears; while pulsing the low level clears
    always_comb begin
        originHit = 1'b0;
        if (pulse.originReturn && env_reg[axis_regs_pkg::ENV_ORIGIN_CLEAR]) begin
            if (pulse.active) begin
                originHit = !originInput;
            end else begin
                originHit = originFell;
            end
        end
    end

    assign countEnable = pulse.step && !env_reg[axis_regs_pkg::ENV_COUNT_INHIBIT];
    assign countUp = !pulse.minus ^ env_reg[axis_regs_pkg::ENV_REVERSE];

    // both candidates formed every cycle; modulo 2^24 gives the wrap for free
    always_comb begin
        positionUp = position_reg + axis_regs_pkg::POSITION_ONE;
        positionDown = position_reg - axis_regs_pkg::POSITION_ONE;
    end

    // wrap flags: the step that would carry or borrow out of bit 23
    always_comb begin
        upWrap = (position_reg == axis_regs_pkg::POSITION_ALL_ONES);
        downWrap = (position_reg == axis_regs_pkg::POSITION_RESET);
    end

    // next counter value; host load beats origin clear, which beats counting
    always_comb begin
        position_next = position_reg;
        wrapEvent = 1'b0;
        if (positionWrite) begin
            position_next = regRequest.wdata;
        end else if (originHit) begin
            position_next = axis_regs_pkg::POSITION_RESET;
        end else if (countEnable) begin
            // plain modulo arithmetic, no sign handling needed
            if (countUp) begin
                position_next = positionUp;
                wrapEvent = upWrap;
            end else begin
                position_next = positionDown;
                wrapEvent = downWrap;
            end
        end
    end

    // position counter storage
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            position_reg <= axis_regs_pkg::POSITION_RESET;
        end else begin
            position_reg <= position_next;
        end
    end

    // port output latch; bits 4..23 of the write are discarded
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            portLevel_reg <= axis_regs_pkg::PORT_RESET;
        end else if (portWrite) begin
            portLevel_reg <= regRequest.wdata[axis_regs_pkg::PORTS-1:0];
        end
    end

    // shared terminal drivers, one per phase/port pair; level and enable kept apart
    for (genvar i = 0; i < axis_regs_pkg::PORTS; i++) begin : gen_term
        // drive level: sequencer phase in phase mode, latched port level otherwise
        always_ff @(posedge clock) begin
            if (!reset_n) begin
                terminalOut[i] <= 1'b0;
            end else if (!env_reg[axis_regs_pkg::ENV_TERM_SELECT]) begin
                terminalOut[i] <= phaseOutputs[i];
            end else begin
                // latched level only reaches the pin while the port is an output
                terminalOut[i] <= portLevel_reg[i];
            end
        end

        // drive enable: phase outputs always drive; ports follow their direction bit
        always_ff @(posedge clock) begin
            if (!reset_n) begin
                terminalOe[i] <= 1'b1;
            end else if (!env_reg[axis_regs_pkg::ENV_TERM_SELECT]) begin
                terminalOe[i] <= 1'b1;
            end else begin
                terminalOe[i] <= !portDirIn[i];
            end
        end
    end

    // event sources for the interrupt status
    always_comb begin
        irqEvents = '0;
        irqEvents[axis_regs_pkg::IRQ_ORIGIN_CLEAR] = originHit;
        irqEvents[axis_regs_pkg::IRQ_WRAP] = wrapEvent;
    end

    // clear-on-read next value; an event in the read cycle stays set, set wins
    always_comb begin
        if (statusRead) begin
            irqStatus_next = irqEvents;
        end else begin
            irqStatus_next = irqStatus_reg | irqEvents;
        end
    end

    // sticky status storage
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            irqStatus_reg <= axis_regs_pkg::IRQ_RESET;
        end else begin
            irqStatus_reg <= irqStatus_next;
        end
    end

    // interrupt mask
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            irqMask_reg <= axis_regs_pkg::IRQ_RESET;
        end else if (maskWrite) begin
            irqMask_reg <= regRequest.wdata[axis_regs_pkg::IRQ_W-1:0];
        end
    end

    // unmasked pending events; the flop below keeps the output glitch free
    always_comb begin
        irqPending = |(irqStatus_reg & irqMask_reg);
    end

    // level interrupt; one cycle behind status because outputs come from flops
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            interrupt <= 1'b0;
        end else begin
            interrupt <= irqPending;
        end
    end

    // counter word, full width
    always_comb begin
        positionWord = position_reg;
    end

    // extended status on the low bits, upper bits zero
    always_comb begin
        extStatusWord = '0;
        extStatusWord[axis_regs_pkg::EXT_W-1:0] = extendedStatus;
    end

    // product byte on the top byte; mode bit mirrors the compat setting
    always_comb begin
        productWord = '0;
        productWord[axis_regs_pkg::PROD_LSB + axis_regs_pkg::PROD_CODE_LSB
            +: axis_regs_pkg::PROD_CODE_W] = axis_regs_pkg::PRODUCT_CODE;
        productWord[axis_regs_pkg::PROD_LSB + axis_regs_pkg::PROD_VERSION] =
            axis_regs_pkg::PRODUCT_VERSION;
        productWord[axis_regs_pkg::PROD_LSB + axis_regs_pkg::PROD_MODE] =
            env_reg[axis_regs_pkg::ENV_COMPAT];
    end

    // environment readback, setting bits only
    always_comb begin
        envWord = '0;
        envWord[axis_regs_pkg::ENV_W-1:0] = env_reg;
    end

    // port word: live terminal levels, two monitor inputs, top bits forced low
    always_comb begin
        portWord = '0;
        portWord[axis_regs_pkg::PORTS-1:0] = terminalIn;
        portWord[axis_regs_pkg::PORT_UPDOWN] = updownTerminal;
        portWord[axis_regs_pkg::PORT_FASTHOLD] = fastholdTerminal;
    end

    // interrupt status and mask readback
    always_comb begin
        irqStatusWord = '0;
        irqStatusWord[axis_regs_pkg::IRQ_W-1:0] = irqStatus_reg;
        irqMaskWord = '0;
        irqMaskWord[axis_regs_pkg::IRQ_W-1:0] = irqMask_reg;
    end

    // read word selection; unmapped codes return zero
    always_comb begin
        readWord = '0;
        if (selHit(regRequest.sel, axis_regs_pkg::SEL_POSITION)) begin
            readWord = positionWord;
        end else if (selHit(regRequest.sel, axis_regs_pkg::SEL_EXT_STATUS)) begin
            readWord = extStatusWord;
        end else if (selHit(regRequest.sel, axis_regs_pkg::SEL_PRODUCT_READ)) begin
            readWord = productWord;
        end else if (selHit(regRequest.sel, axis_regs_pkg::SEL_ENV_READ)) begin
            readWord = envWord;
        end else if (selHit(regRequest.sel, axis_regs_pkg::SEL_PORT)) begin
            readWord = portWord;
        end else if (selHit(regRequest.sel, axis_regs_pkg::SEL_IRQ_STATUS)) begin
            readWord = irqStatusWord;
        end else if (selHit(regRequest.sel, axis_regs_pkg::SEL_IRQ_MASK)) begin
            readWord = irqMaskWord;
        end
    end

    // read data valid only in the cycle after the strobe, zero otherwise
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            regReadData <= '0;
        end else if (hostRead) begin
            regReadData <= readWord;
        end else begin
            regReadData <= '0;
        end
    end

    // counter mirror for the pulse logic
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            positionCount <= axis_regs_pkg::POSITION_RESET;
        end else begin
            positionCount <= position_next;
        end
    end

endmodule

// *** test/terminal_pin_model.sv ***
// Purpose: board-side model of the four shared phase/port terminals
// Assumes: terminals carry a pull-up; outside drivers are set by the bench
// Notes: both sides driving one terminal gives an unknown level on purpose
`timescale 1ns/1ps

module terminal_pin_model (
    input wire logic [3:0] terminalOut,
    input wire logic [3:0] terminalOe,
    input wire logic [3:0] extDrive,
    input wire logic [3:0] extLevel,
    output logic [3:0] terminalIn
);
    // resolve each wire; a released terminal floats up through the pull-up
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (terminalOe[i] && extDrive[i]) begin
                terminalIn[i] = 1'bx; // contention is never a valid level
            end else if (terminalOe[i]) begin
                terminalIn[i] = terminalOut[i];
            end else begin
                terminalIn[i] = extDrive[i] ? extLevel[i] : 1'b1;
            end
        end
    end
endmodule

// *** test/axis_position_status_regs_sva.sv ***
// Purpose: port-level checks of the axis register group
// Assumes: one clock, synchronous active-low reset
// Notes: environment settings are hidden here, so counting checks allow a hold
`timescale 1ns/1ps

module axis_regs_checker (
    input wire logic clock,
    input wire logic reset_n,
    input wire axis_regs_pkg::reg_req_s regRequest,
    input wire logic [23:0] regReadData,
    input wire axis_regs_pkg::pulse_s pulse,
    input wire logic [15:0] extendedStatus,
    input wire logic [3:0] terminalIn,
    input wire logic updownTerminal,
    input wire logic fastholdTerminal,
    input wire logic [23:0] positionCount
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    // host counter write, the only source outranking counting and clearing
    logic cntWrite;
    assign cntWrite = regRequest.write && regRequest.sel == 4'h8;

    a_read_idle_zero: assert property (
        !regRequest.read |=> regReadData == 24'h000000) else $error("read data not idle");
    a_count_load: assert property (
        cntWrite |=> positionCount == $past(regRequest.wdata)) else $error("counter load");
    a_count_read: assert property (
        regRequest.read && regRequest.sel == 4'h8 |=> regReadData == $past(positionCount))
        else $error("counter read");
    a_status_read: assert property (
        regRequest.read && regRequest.sel == 4'h9 |=> regReadData == {8'h00, $past(extendedStatus)})
        else $error("status read");
    a_port_read: assert property (
        regRequest.read && regRequest.sel == 4'hA |=> regReadData ==
        {18'h00000, $past(fastholdTerminal), $past(updownTerminal), $past(terminalIn)})
        else $error("port read");
    a_product_read: assert property (
        regRequest.read && regRequest.sel == 4'h7 |=> regReadData[15:0] == 16'h0000
        && regReadData[18:17] == 2'b00) else $error("product read");
    a_count_hold: assert property (
        !pulse.step && !cntWrite && !pulse.originReturn |=> $stable(positionCount))
        else $error("counter moved without pulse");
    a_count_step: assert property (
        pulse.step && !cntWrite && !pulse.originReturn |=> 24'(positionCount - $past(positionCount))
        inside {24'h000001, 24'hFFFFFF, 24'h000000}) else $error("counter step size");
endmodule

bind axis_position_status_regs axis_regs_checker u_axis_regs_checker (
    .clock(clock), .reset_n(reset_n), .regRequest(regRequest), .regReadData(regReadData),
    .pulse(pulse), .extendedStatus(extendedStatus), .terminalIn(terminalIn),
    .updownTerminal(updownTerminal), .fastholdTerminal(fastholdTerminal),
    .positionCount(positionCount));

// *** test/axis_position_status_regs_tb_top.sv ***
// Purpose: self-checking bench for the axis register group
// Assumes: bench drives inputs with non-blocking writes after rising edges
// Notes: wrap events earlier in the run feed the interrupt scenario
`timescale 1ns/1ps

module axis_position_status_regs_tb_top;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    axis_regs_pkg::reg_req_s regRequest = '0;
    axis_regs_pkg::pulse_s pulse = '0;
    logic originInput = 1'b1;
    logic [15:0] extendedStatus = 16'hA5C3;
    logic [3:0] phaseOutputs = 4'h9;
    logic [3:0] extDrive = 4'h0;
    logic [3:0] extLevel = 4'h0;
    logic updownTerminal = 1'b1;
    logic fastholdTerminal = 1'b0;
    logic [3:0] terminalIn, terminalOut, terminalOe;
    logic [23:0] regReadData, positionCount, rdata;
    logic interrupt;
    int error_cnt = 0;
    int checks = 0;
    int cycleCnt = 0;

    axis_position_status_regs u_axis_position_status_regs (.clock(clock), .reset_n(reset_n),
        .regRequest(regRequest), .regReadData(regReadData), .pulse(pulse),
        .originInput(originInput), .extendedStatus(extendedStatus), .phaseOutputs(phaseOutputs),
        .terminalIn(terminalIn), .updownTerminal(updownTerminal),
        .fastholdTerminal(fastholdTerminal), .terminalOut(terminalOut),
        .terminalOe(terminalOe), .positionCount(positionCount), .interrupt(interrupt));
    terminal_pin_model u_terminal_pin_model (.terminalOut(terminalOut),
        .terminalOe(terminalOe), .extDrive(extDrive), .extLevel(extLevel),
        .terminalIn(terminalIn));

    // free-running clock
    always #2 clock = ~clock;

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // a hang is cut short well beyond the roughly 70 cycles the run needs
    always @(posedge clock) begin
        cycleCnt++;
        if (cycleCnt == 5000) begin
            error_cnt++;
            give_verdict();
        end
    end

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] sel, input logic [23:0] data);
        @(posedge clock);
        regRequest.sel <= sel;
        regRequest.wdata <= data;
        regRequest.write <= 1'b1;
        @(posedge clock);
        regRequest.write <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] sel, output logic [23:0] data);
        @(posedge clock);
        regRequest.sel <= sel;
        regRequest.read <= 1'b1;
        @(posedge clock);
        regRequest.read <= 1'b0;
        #1;
        data = regReadData;
    endtask

    task automatic step(input logic minus);
        @(posedge clock);
        pulse.step <= 1'b1;
        pulse.minus <= minus;
        @(posedge clock);
        pulse.step <= 1'b0;
        #1;
    endtask

    task automatic t_reset();
        rd(axis_regs_pkg::SEL_PRODUCT_READ, rdata);
        chk(rdata, {axis_regs_pkg::PRODUCT_CODE, axis_regs_pkg::PRODUCT_VERSION, 19'h0});
        chk({20'h0, terminalOut}, {20'h0, phaseOutputs});
        chk({20'h0, terminalOe}, 24'h00000F);
        rd(axis_regs_pkg::SEL_PORT, rdata);
        chk(rdata, 24'h000019);
        $display("test reset done");
    endtask

    task automatic t_counter();
        wr(axis_regs_pkg::SEL_POSITION, 24'hFFFFFF);
        step(1'b0);
        chk(positionCount, 24'h000000);
        step(1'b1);
        chk(positionCount, 24'hFFFFFF);
        wr(axis_regs_pkg::SEL_POSITION, 24'h800000);
        rd(axis_regs_pkg::SEL_POSITION, rdata);
        chk(rdata, 24'h800000);
        wr(axis_regs_pkg::SEL_ENV_WRITE, 24'h000200);
        step(1'b0);
        chk(positionCount, 24'h7FFFFF);
        wr(axis_regs_pkg::SEL_ENV_WRITE, 24'h000100);
        step(1'b0);
        chk(positionCount, 24'h7FFFFF);
        $display("test counter done");
    endtask

    task automatic t_irq();
        chk({23'h0, interrupt}, 24'h000000);
        wr(axis_regs_pkg::SEL_IRQ_MASK, 24'h000003);
        repeat (2) @(posedge clock);
        #1;
        chk({23'h0, interrupt}, 24'h000001);
        rd(axis_regs_pkg::SEL_IRQ_STATUS, rdata);
        chk(rdata, 24'h000002);
        repeat (2) @(posedge clock);
        #1;
        chk({23'h0, interrupt}, 24'h000000);
        $display("test interrupt done");
    endtask

    // origin clear: at low level while pulsing, only on a falling edge when idle
    task automatic t_origin();
        wr(axis_regs_pkg::SEL_ENV_WRITE, 24'h000080);
        wr(axis_regs_pkg::SEL_POSITION, 24'h000123);
        pulse.originReturn <= 1'b1;
        pulse.active <= 1'b1;
        originInput <= 1'b0;
        repeat (2) @(posedge clock);
        #1;
        chk(positionCount, 24'h000000);
        @(posedge clock);
        pulse.active <= 1'b0;
        wr(axis_regs_pkg::SEL_POSITION, 24'h000005);
        repeat (2) @(posedge clock);
        #1;
        chk(positionCount, 24'h000005);
        @(posedge clock);
        originInput <= 1'b1;
        @(posedge clock);
        originInput <= 1'b0;
        repeat (2) @(posedge clock);
        #1;
        chk(positionCount, 24'h000000);
        @(posedge clock);
        pulse.originReturn <= 1'b0;
        $display("test origin done");
    endtask

    task automatic t_port();
        wr(axis_regs_pkg::SEL_ENV_WRITE, 24'h00C800);
        extDrive <= 4'hC;
        extLevel <= 4'h8;
        wr(axis_regs_pkg::SEL_PORT, 24'h0000F5);
        repeat (2) @(posedge clock);
        #1;
        chk({20'h0, terminalOe}, 24'h000003);
        chk({22'h0, terminalOut[1:0]}, 24'h000001);
        rd(axis_regs_pkg::SEL_PORT, rdata);
        chk(rdata, 24'h000019);
        $display("test port done");
    endtask

    task automatic t_status();
        wr(axis_regs_pkg::SEL_EXT_STATUS, 24'hFFFFFF);
        rd(axis_regs_pkg::SEL_EXT_STATUS, rdata);
        chk(rdata, 24'h00A5C3);
        chk(positionCount, 24'h000000);
        $display("test status done");
    endtask

    initial begin
        repeat (12) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        t_reset();
        t_counter();
        t_irq();
        t_origin();
        t_port();
        t_status();
        give_verdict();
    end
endmodule
